// [logic/igp_pkg.sv]
// Functional notes
// - controller inserts 3.0 us leg dead time
// - on pulses at least 1.5 us, except those cut short by a stop
// - off pulses 3.0 us, 3.5 us high current
// - switching never above 20 kHz
// - controller stops drive on overtemperature
package igp_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned DEAD_NS         = 3000;
  localparam int unsigned MIN_ON_NS       = 1500;
  localparam int unsigned MIN_OFF_NS      = 3000;
  localparam int unsigned MIN_OFF_HI_NS   = 3500;
  localparam int unsigned MIN_PERIOD_NS   = 50_000;
  localparam int unsigned NS_PER_S        = 1_000_000_000;
  // least times round up
  localparam int unsigned DEAD_CYC    = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned ON_CYC      = (MIN_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned OFF_CYC     = (MIN_OFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned OFF_HI_CYC  = (MIN_OFF_HI_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PERIOD_CYC  = (MIN_PERIOD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W       = 12;
  localparam int unsigned PHASES      = 3;
  typedef enum logic [2:0] {
    IGP_RUN   = 3'h1,
    IGP_TRIP  = 3'h2,
    IGP_ARM   = 3'h4
  } igp_state_e;
endpackage

// [logic/igp_leg_if.sv]
`timescale 1ns/10ps
interface igp_leg_if;
  logic reqHi;
  logic reqLo;
  logic inhibit;
  logic hiCurrent;
  logic gateHi;
  logic gateLo;
  modport ctl (output reqHi, output reqLo, output inhibit, output hiCurrent, input gateHi, input gateLo);
  modport leg (input reqHi, input reqLo, input inhibit, input hiCurrent, output gateHi, output gateLo);
endinterface

// [logic/igp_leg.sv]
`timescale 1ns/10ps
module igp_leg (
  // clock and reset
  input wire logic  sys_clk,
  input wire logic  rst_n,
  // leg control
  igp_leg_if.leg    lg
);
  typedef enum logic [3:0] {
    LEG_OFF  = 4'h1,
    LEG_DEAD = 4'h2,
    LEG_HI   = 4'h4,
    LEG_LO   = 4'h8
  } igp_leg_e;
  igp_leg_e                     st_r;
  igp_leg_e                     st_nxt;
  logic [igp_pkg::CNT_W-1:0]    cnt_r;
  logic [igp_pkg::CNT_W-1:0]    cnt_nxt;
  logic [igp_pkg::CNT_W-1:0]    perCnt_r;
  logic                         gateHi_r;
  logic                         gateLo_r;
  wire  [igp_pkg::CNT_W-1:0]    offMin;
  wire                          onDone;
  wire                          offDone;
  wire                          perDone;
  wire                          wantHi;
  wire                          wantLo;
  assign offMin  = lg.hiCurrent ? igp_pkg::CNT_W'(igp_pkg::OFF_HI_CYC) : igp_pkg::CNT_W'(igp_pkg::OFF_CYC);
  assign onDone  = cnt_r >= igp_pkg::CNT_W'(igp_pkg::ON_CYC);
  assign offDone = cnt_r >= offMin && cnt_r >= igp_pkg::CNT_W'(igp_pkg::DEAD_CYC);
  assign perDone = perCnt_r >= igp_pkg::CNT_W'(igp_pkg::PERIOD_CYC);
  assign wantHi  = lg.reqHi && !lg.reqLo;
  assign wantLo  = lg.reqLo && !lg.reqHi;
  assign lg.gateHi = gateHi_r;
  assign lg.gateLo = gateLo_r;
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
    case (st_r)
      LEG_HI, LEG_LO: begin
        if (lg.inhibit) begin
          st_nxt  = LEG_DEAD;
          cnt_nxt = '0;
        end else if (onDone && !((st_r == LEG_HI) ? wantHi : wantLo)) begin
          st_nxt  = LEG_DEAD;
          cnt_nxt = '0;
        end
      end
      LEG_DEAD: begin
        if (offDone) begin
          st_nxt = LEG_OFF;
        end
      end
      default: begin
        if (!lg.inhibit && perDone && (wantHi || wantLo)) begin
          st_nxt     = wantHi ? LEG_HI : LEG_LO;
          cnt_nxt    = '0;
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r     <= LEG_DEAD;
      cnt_r    <= '0;
      perCnt_r <= '0;
      gateHi_r <= 1'b0;
      gateLo_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      gateHi_r <= (st_nxt == LEG_HI);
      gateLo_r <= (st_nxt == LEG_LO);
      if (st_r == LEG_OFF && st_nxt != LEG_OFF) begin
        perCnt_r <= '0;
      end else if (perCnt_r != '1) begin
        perCnt_r <= perCnt_r + 1'b1;
      end
    end
  end
  property p_noShoot;
    @(posedge sys_clk) disable iff (!rst_n) !(gateHi_r && gateLo_r);
  endproperty
  a_noShoot: assert property (p_noShoot) else $error("both gates of a leg on");
  property p_deadGap;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(gateHi_r | gateLo_r) |-> !(gateHi_r | gateLo_r) [*8] ##1 !(gateHi_r | gateLo_r) [*8];
  endproperty
  a_deadGap: assert property (p_deadGap) else $error("dead time too short");
  property p_minOn;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(gateHi_r) |-> (gateHi_r || lg.inhibit) [*8];
  endproperty
  a_minOn: assert property (p_minOn) else $error("high gate pulse too short");
  property p_minOnLo;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(gateLo_r) |-> (gateLo_r || lg.inhibit) [*8];
  endproperty
  a_minOnLo: assert property (p_minOnLo) else $error("low gate pulse too short");
  property p_minOff;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(gateHi_r) |-> !gateHi_r [*8];
  endproperty
  a_minOff: assert property (p_minOff) else $error("off pulse too short");
endmodule

// [logic/igp_ctrl.sv]
`timescale 1ns/10ps
module igp_ctrl #(
  parameter int unsigned PHASES = igp_pkg::PHASES
) (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst_n,
  // pwm requests from modulator
  input wire logic [PHASES-1:0]  reqHi,
  input wire logic [PHASES-1:0]  reqLo,
  input wire logic               hiCurrent,
  // supervision
  input wire logic               overTemp,
  input wire logic               restart,
  // fault line pin, open drain input only
  input wire logic               faultIndication_n,
  // gate pins, high active
  output logic [PHASES-1:0]      gateHi,
  output logic [PHASES-1:0]      gateLo,
  // status
  output logic                   tripped
);
  igp_pkg::igp_state_e  st_r;
  igp_pkg::igp_state_e  st_nxt;
  logic                 fltS1_r;
  logic                 fltS2_r;
  logic                 tempS1_r;
  logic                 tempS2_r;
  logic [PHASES-1:0]    seenLowHi_r;
  logic [PHASES-1:0]    seenLowLo_r;
  logic [PHASES-1:0]    gateHiW;
  logic [PHASES-1:0]    gateLoW;
  logic                 tripped_r;
  wire                  faultSeen;
  wire                  stopNow;
  wire                  allLow;
  wire                  inhibitW;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fltS1_r  <= 1'b1;
      fltS2_r  <= 1'b1;
      tempS1_r <= 1'b0;
      tempS2_r <= 1'b0;
    end else begin
      fltS1_r  <= faultIndication_n;
      fltS2_r  <= fltS1_r;
      tempS1_r <= overTemp;
      tempS2_r <= tempS1_r;
    end
  end
  assign faultSeen = !fltS2_r;
  assign stopNow  = faultSeen || tempS2_r;
  assign allLow   = (&seenLowHi_r) && (&seenLowLo_r);
  assign inhibitW = stopNow || (st_r != igp_pkg::IGP_RUN);
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      igp_pkg::IGP_RUN: begin
        if (stopNow) begin
          st_nxt = igp_pkg::IGP_TRIP;
        end
      end
      igp_pkg::IGP_TRIP: begin
        if (!stopNow && restart) begin
          st_nxt = igp_pkg::IGP_ARM;
        end
      end
      default: begin
        if (stopNow) begin
          st_nxt = igp_pkg::IGP_TRIP;
        end else if (allLow) begin
          st_nxt = igp_pkg::IGP_RUN;
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r        <= igp_pkg::IGP_ARM;
      seenLowHi_r <= '0;
      seenLowLo_r <= '0;
      tripped_r   <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      tripped_r <= (st_nxt == igp_pkg::IGP_TRIP);
      if (st_r != igp_pkg::IGP_ARM) begin
        seenLowHi_r <= '0;
        seenLowLo_r <= '0;
      end else begin
        seenLowHi_r <= seenLowHi_r | ~reqHi;
        seenLowLo_r <= seenLowLo_r | ~reqLo;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : gLeg
      igp_leg_if lif ();
      assign lif.reqHi     = reqHi[g];
      assign lif.reqLo     = reqLo[g];
      assign lif.inhibit   = inhibitW;
      assign lif.hiCurrent = hiCurrent;
      assign gateHiW[g]    = lif.gateHi;
      assign gateLoW[g]    = lif.gateLo;
      igp_leg u_leg (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .lg      (lif.leg)
      );
    end
  endgenerate
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gateHi <= '0;
      gateLo <= '0;
    end else begin
      gateHi <= gateHiW & {PHASES{!inhibitW}};
      gateLo <= gateLoW & {PHASES{!inhibitW}};
    end
  end
  assign tripped = tripped_r;
  property p_faultOff;
    @(posedge sys_clk) disable iff (!rst_n)
      faultSeen |-> ##1 (gateHi == '0 && gateLo == '0);
  endproperty
  a_faultOff: assert property (p_faultOff) else $error("gates driven during fault");
  property p_tempOff;
    @(posedge sys_clk) disable iff (!rst_n)
      tempS2_r |-> ##1 (gateHi == '0 && gateLo == '0);
  endproperty
  a_tempOff: assert property (p_tempOff) else $error("gates driven at overtemperature");
  // no gate on right after arm
  property p_freshEdge;
    @(posedge sys_clk) disable iff (!rst_n)
      (st_r == igp_pkg::IGP_ARM) |-> ##1 (gateHi == '0 && gateLo == '0);
  endproperty
  a_freshEdge: assert property (p_freshEdge) else $error("gate on before fresh edge");
endmodule

// [tb/igp_dev_model.sv]
`timescale 1ns/10ps
module igp_dev_model #(
  parameter int FLT_CYC = 200
) (
  // clock
  input wire logic        sys_clk,
  // gate pins and fault causes
  input wire logic [2:0]  gateHi,
  input wire logic [2:0]  gateLo,
  input wire logic        scTrip,
  input wire logic        uvLow,
  input wire logic [2:0]  uvFloat,
  // pins back to host
  output logic            faultIndication_n,
  output logic [2:0]      swHi,
  output logic [2:0]      swLo
);
  int         fltCnt = 0;
  logic [2:0] blkHi  = '0;
  logic [2:0] blkLo  = '0;
  logic [2:0] hiQ    = '0;
  logic [2:0] loQ    = '0;
  always @(posedge sys_clk) begin
    hiQ <= gateHi;
    loQ <= gateLo;
    if (scTrip || uvLow) fltCnt <= FLT_CYC;
    else if (fltCnt > 0) fltCnt <= fltCnt - 1;
    // low side held until fresh edge
    blkLo <= (scTrip || uvLow) ? 3'h7 : (fltCnt == 0) ? blkLo & ~(gateLo & ~loQ) : blkLo;
    // one high side only, no fault
    blkHi <= uvFloat | (blkHi & ~(gateHi & ~hiQ));
  end
  assign swHi = gateHi & ~blkHi;
  assign swLo = gateLo & ~blkLo;
  assign faultIndication_n = (fltCnt > 0 || uvLow) ? 1'h0 : 1'h1;
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic       sys_clk, rst_n, hiCurrent, overTemp, restart, scTrip, uvLow;
  logic       faultIndication_n, tripped;
  logic [2:0] reqHi, reqLo, gateHi, gateLo, uvFloat, swHi, swLo;
  logic [5:0] gPrev = '0;
  wire  [5:0] g = {gateLo, gateHi};
  int         mismatches = 0;
  int         compares = 0;
  int         cyc = 0;
  int         lastOn [6];
  int         lastOff [6];

  igp_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reqHi(reqHi), .reqLo(reqLo), .hiCurrent(hiCurrent),
    .overTemp(overTemp), .restart(restart), .faultIndication_n(faultIndication_n), .gateHi(gateHi),
    .gateLo(gateLo), .tripped(tripped));
  igp_dev_model dev (.sys_clk(sys_clk), .gateHi(gateHi), .gateLo(gateLo), .scTrip(scTrip), .uvLow(uvLow),
    .uvFloat(uvFloat), .faultIndication_n(faultIndication_n), .swHi(swHi), .swLo(swLo));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  function automatic int ns2cyc(int ns);
    return (ns * 40 + 999) / 1000;
  endfunction

  task automatic check(logic [31:0] got, logic [31:0] exp, string msg);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // width and spacing watch on all six gates, sampled settled
  always @(negedge sys_clk) begin
    for (int i = 0; i < 6; i++) begin
      if (!rst_n) begin
        lastOff[i] = cyc;
        lastOn[i] = cyc - ns2cyc(50000);
      end else if (g[i] && !gPrev[i]) begin
        check(!g[(i + 3) % 6] && cyc - lastOff[(i + 3) % 6] >= ns2cyc(3000), 32'h1, "dead");
        check(cyc - lastOff[i] >= ns2cyc(hiCurrent ? 3500 : 3000), 32'h1, "off width");
        check(cyc - lastOn[i] >= ns2cyc(50000), 32'h1, "rate");
        lastOn[i] = cyc;
      end else if (!g[i] && gPrev[i]) begin
        // forced cuts may be short on purpose
        if (!tripped && !overTemp && faultIndication_n) check(cyc - lastOn[i] >= ns2cyc(1500), 32'h1, "on width");
        lastOff[i] = cyc;
      end
    end
    gPrev = g;
  end

  task automatic trip_cycle(int cause);
    reqHi = 3'h1;
    reqLo = 3'h6;
    tick(2500);
    check(g, 6'h31, "running");
    scTrip = (cause == 0);
    uvLow = (cause == 1);
    overTemp = (cause == 2);
    tick(1);
    if (cause != 2) check(swLo, 32'h0, "low side cut");
    scTrip = 1'h0;
    for (int k = 0; k < 6 && g != 6'h00; k++) tick(1);
    check(g, 6'h00, "gates cut");
    tick(cause == 0 ? 5 : 500);
    check(faultIndication_n, cause == 2, "fault pin");
    restart = 1'h1;
    tick(1);
    restart = 1'h0;
    tick(5);
    if (cause != 2) check(tripped, 32'h1, "restart in fault");
    uvLow = 1'h0;
    overTemp = 1'h0;
    tick(300);
    restart = 1'h1;
    tick(1);
    restart = 1'h0;
    tick(300);
    check(g, 6'h00, "held level no start");
    reqHi = 3'h0;
    reqLo = 3'h0;
    tick(3);
    reqHi = 3'h1;
    for (int k = 0; k < 2500 && gateHi[0] !== 1'h1; k++) tick(1);
    check(gateHi[0], 32'h1, "fresh edge start");
    check(swHi[0], 32'h1, "switch back on");
    $display("test trip cause %0d done", cause);
  endtask

  initial begin
    rst_n = 1'h0;
    reqHi = 3'h0;
    reqLo = 3'h0;
    hiCurrent = 1'h0;
    overTemp = 1'h0;
    restart = 1'h0;
    scTrip = 1'h0;
    uvLow = 1'h0;
    uvFloat = 3'h0;
    void'($urandom(15882));
    tick(5);
    rst_n = 1'h1;
    tick(1);
    check(g, 6'h00, "reset gates");
    check(tripped, 32'h0, "reset trip");
    $display("test reset done");
    for (int h = 0; h < 2; h++) begin
      hiCurrent = h[0];
      repeat (40) begin
        reqHi = 3'($urandom);
        reqLo = 3'($urandom);
        tick($urandom_range(3, 300));
      end
      reqHi = 3'h0;
      reqLo = 3'h0;
      tick(200);
    end
    $display("test random done");
    for (int c = 0; c < 3; c++) trip_cycle(c);
    // float supply trip must not reach the host as a fault
    uvFloat = 3'h2;
    tick(50);
    uvFloat = 3'h0;
    check(faultIndication_n, 32'h1, "float no fault");
    check(tripped, 32'h0, "float no trip");
    $display("test float done");
    final_report();
  end

  // hang guard, roughly three and a half times the expected run
  initial begin
    #(25 * 80000);
    mismatches++;
    final_report();
  end
endmodule
